/* File: pcr_port_regs.sv */
// Our own choice: the APB interface to the registers.
`timescale 1ns/1ps
// Operation
// - The fault distance is nine bits, bit 8 in the diagnostic control register, bits 7:0 in a result register.
// - With negotiation disabled, speed and duplex come from the forced bits of the same register.
// - Forced speed one gives 100 Mbit/s, zero gives 10 Mbit/s, and it resets to one.
// - Forced duplex (full at one, half at zero, reset half) applies when negotiation is off or has failed.
// - A set LED-off bit drives all three LED outputs of the port high.
// - A set transmitter-off bit disables the port's transmitter, and it resets to zero.
// - Writing one to restart-negotiation restarts it and the bit clears itself.
// - The fault distance result register exists only for ports three and four.
// - Negotiation and LED/transmitter control registers exist for ports one to four at a stride of sixteen.
// - Setting the cable test go bit starts a test on ports three and four only; the bit clears itself on completion unless go is rewritten in that cycle.
// - The cable test outcome is 0 normal, 1 open, 2 short, 3 failed.
module pcr_port_regs
    import pcr_pkg::*;
#(
    parameter int ADDR_W = 12,
    parameter int NPORT = PORT_COUNT
) (
    input wire logic clock_i,
    input wire logic rstn_i,
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [ADDR_W-1:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    input wire logic [3:0] pstrb_i,
    output logic [31:0] prdata_o,
    output logic pready_o,
    output logic pslverr_o,
    input wire logic [NPORT*NIBBLE_W-1:0] line_receive_pair_i,
    input wire logic [NPORT-1:0] line_receive_valid_i,
    input wire logic [NPORT*NIBBLE_W-1:0] mac_tx_data_i,
    input wire logic [NPORT-1:0] mac_tx_valid_i,
    output logic [NPORT*NIBBLE_W-1:0] line_transmit_pair_o,
    output logic [NPORT-1:0] line_transmit_valid_o,
    output logic [NPORT-1:0] transmitter_off_o,
    input wire logic [NPORT-1:0] an_speed_100_i,
    input wire logic [NPORT-1:0] an_full_duplex_i,
    input wire logic [NPORT-1:0] an_failed_i,
    output logic [NPORT-1:0] an_enable_o,
    output logic [NPORT-1:0] an_restart_o,
    output logic [NPORT-1:0] link_speed_100_o,
    output logic [NPORT-1:0] link_full_duplex_o,
    input wire logic [NPORT*3-1:0] led_normal_i,
    output logic [NPORT-1:0] port_led_out_0_o,
    output logic [NPORT-1:0] port_led_out_1_o,
    output logic [NPORT-1:0] port_led_out_2_o,
    output logic [NPORT-1:0] cable_test_start_o,
    input wire logic [NPORT-1:0] cable_test_done_i,
    input wire logic [NPORT*2-1:0] cable_test_outcome_i,
    input wire logic [NPORT*9-1:0] fault_distance_count_i,
    input wire logic [NPORT-1:0] cable_short10_i
);
    logic [7:0] reg_idx;
    logic setup_phase;
    logic wr_access;
    logic aligned;

    logic [NPORT-1:0] loopback_q;
    logic [NPORT-1:0] an_disable_q;
    logic [NPORT-1:0] forced_speed_q;
    logic [NPORT-1:0] forced_duplex_q;
    logic [NPORT-1:0] led_off_q;
    logic [NPORT-1:0] tx_off_q;
    logic [NPORT-1:0] restart_q;
    logic [NPORT-1:0] test_busy;
    logic [NPORT*2-1:0] test_outcome;
    logic [NPORT*9-1:0] test_count;
    logic [NPORT-1:0] test_short10;

    logic [NPORT-1:0] hit_c8;
    logic [NPORT-1:0] hit_c9;
    logic [NPORT-1:0] hit_c10;
    logic [NPORT-1:0] hit_res;
    logic [NPORT*8-1:0] rd_c8;
    logic [NPORT*8-1:0] rd_c9;
    logic [NPORT*8-1:0] rd_c10;
    logic [NPORT*8-1:0] rd_res;

    logic [7:0] rd_byte;
    logic rd_hit;
    logic [31:0] prdata_q;
    logic pslverr_q;
    logic [NPORT*NIBBLE_W-1:0] tx_data_q;
    logic [NPORT-1:0] tx_valid_q;
    logic [NPORT-1:0] led0_q;
    logic [NPORT-1:0] led1_q;
    logic [NPORT-1:0] led2_q;

    assign reg_idx = paddr_i[9:2];
    assign aligned = (paddr_i[1:0] == 2'b00) && (paddr_i[ADDR_W-1:10] == '0);
    assign setup_phase = psel_i && !penable_i;
    assign wr_access = psel_i && penable_i && pwrite_i && pstrb_i[0] && aligned;

    genvar p;
    generate
        for (p = 0; p < NPORT; p++) begin : g_port
            localparam logic [7:0] OFS = 8'(p) * PORT_STRIDE;
            localparam logic COPPER = COPPER_PORTS[p];
            logic [7:0] c8_rd;
            logic go_write;

            // Slots of the fifth port and beyond fall outside this loop
            assign hit_c8[p] = aligned && (reg_idx == PORT1_LOOPBACK_CONTROL_IDX + OFS);
            assign hit_c9[p] = aligned && (reg_idx == PORT1_NEGOTIATION_CONTROL_IDX + OFS);
            assign hit_c10[p] = aligned && (reg_idx == PORT1_LED_TX_CONTROL_IDX + OFS);
            assign hit_res[p] = COPPER && aligned && (reg_idx == PORT1_LOOPBACK_CONTROL_IDX
                                + OFS + 8'h01);
            assign go_write = COPPER && wr_access && hit_c8[p] && pwdata_i[C8_GO_BIT];

            always_ff @(posedge clock_i or negedge rstn_i) begin
                if (!rstn_i) begin
                    loopback_q[p] <= 1'b0;
                    an_disable_q[p] <= C9_AN_DISABLE_RESET;
                    forced_speed_q[p] <= C9_SPEED_RESET;
                    forced_duplex_q[p] <= C9_DUPLEX_RESET;
                    led_off_q[p] <= 1'b0;
                    tx_off_q[p] <= 1'b0;
                end else if (wr_access) begin
                    if (hit_c8[p]) begin
                        loopback_q[p] <= pwdata_i[C8_LOOPBACK_BIT];
                    end
                    if (hit_c9[p]) begin
                        an_disable_q[p] <= pwdata_i[C9_AN_DISABLE_BIT];
                        forced_speed_q[p] <= pwdata_i[C9_SPEED_BIT];
                        forced_duplex_q[p] <= pwdata_i[C9_DUPLEX_BIT];
                    end
                    if (hit_c10[p]) begin
                        led_off_q[p] <= pwdata_i[C10_LED_OFF_BIT];
                        tx_off_q[p] <= pwdata_i[C10_TX_OFF_BIT];
                    end
                end
            end

            // Restart is a one-cycle strobe, so it reads back as one only in a read whose setup cycle directly follows the write
            always_ff @(posedge clock_i or negedge rstn_i) begin
                if (!rstn_i) begin
                    restart_q[p] <= 1'b0;
                end else begin
                    restart_q[p] <= wr_access && hit_c10[p] && pwdata_i[C10_RESTART_BIT];
                end
            end

            if (COPPER) begin : g_cable
                pcr_cable_test u_cable_test (
                    .clock_i(clock_i),
                    .rstn_i(rstn_i),
                    .go_write_i(go_write),
                    .done_i(cable_test_done_i[p]),
                    .outcome_i(cable_test_outcome_i[p*2 +: 2]),
                    .count_i(fault_distance_count_i[p*9 +: 9]),
                    .short10_i(cable_short10_i[p]),
                    .busy_o(test_busy[p]),
                    .start_o(cable_test_start_o[p]),
                    .outcome_o(test_outcome[p*2 +: 2]),
                    .count_o(test_count[p*9 +: 9]),
                    .short10_o(test_short10[p])
                );
            end else begin : g_no_cable
                assign test_busy[p] = 1'b0;
                assign cable_test_start_o[p] = 1'b0;
                assign test_outcome[p*2 +: 2] = PCR_CABLE_NORMAL;
                assign test_count[p*9 +: 9] = FAULT_COUNT_RESET;
                assign test_short10[p] = 1'b0;
            end

            always_comb begin
                c8_rd = 8'h00;
                c8_rd[C8_SHORT10_BIT] = test_short10[p];
                c8_rd[C8_OUTCOME_LSB +: 2] = test_outcome[p*2 +: 2];
                c8_rd[C8_GO_BIT] = test_busy[p];
                c8_rd[C8_LOOPBACK_BIT] = loopback_q[p];
                c8_rd[C8_COUNT8_BIT] = test_count[p*9 + 8];
            end

            assign rd_c8[p*8 +: 8] = c8_rd;
            assign rd_c9[p*8 +: 8] = {an_disable_q[p], forced_speed_q[p], forced_duplex_q[p],
                                      C9_RESERVED_VALUE};
            assign rd_c10[p*8 +: 8] = {led_off_q[p], tx_off_q[p], restart_q[p], 5'h00};
            assign rd_res[p*8 +: 8] = test_count[p*9 +: 8];

            // Loopback turns the received nibble round inside the PHY
            always_ff @(posedge clock_i or negedge rstn_i) begin
                if (!rstn_i) begin
                    tx_data_q[p*NIBBLE_W +: NIBBLE_W] <= '0;
                    tx_valid_q[p] <= 1'b0;
                end else if (tx_off_q[p]) begin
                    tx_data_q[p*NIBBLE_W +: NIBBLE_W] <= '0;
                    tx_valid_q[p] <= 1'b0;
                end else if (loopback_q[p]) begin
                    tx_data_q[p*NIBBLE_W +: NIBBLE_W] <=
                        line_receive_pair_i[p*NIBBLE_W +: NIBBLE_W];
                    tx_valid_q[p] <= line_receive_valid_i[p];
                end else begin
                    tx_data_q[p*NIBBLE_W +: NIBBLE_W] <= mac_tx_data_i[p*NIBBLE_W +: NIBBLE_W];
                    tx_valid_q[p] <= mac_tx_valid_i[p];
                end
            end

            always_ff @(posedge clock_i or negedge rstn_i) begin
                if (!rstn_i) begin
                    led0_q[p] <= 1'b1;
                    led1_q[p] <= 1'b1;
                    led2_q[p] <= 1'b1;
                end else begin
                    led0_q[p] <= led_off_q[p] | led_normal_i[p*3];
                    led1_q[p] <= led_off_q[p] | led_normal_i[p*3+1];
                    led2_q[p] <= led_off_q[p] | led_normal_i[p*3+2];
                end
            end

            assign link_speed_100_o[p] = an_disable_q[p] ? forced_speed_q[p]
                                                         : an_speed_100_i[p];
            assign link_full_duplex_o[p] = (an_disable_q[p] || an_failed_i[p])
                                           ? forced_duplex_q[p] : an_full_duplex_i[p];
            assign an_enable_o[p] = !an_disable_q[p];
        end
    endgenerate

    // Read data is snapped in the setup cycle so it comes out of a flop
    always_comb begin
        rd_byte = 8'h00;
        rd_hit = 1'b0;
        for (int i = 0; i < NPORT; i++) begin
            if (hit_c8[i]) begin
                rd_byte = rd_c8[i*8 +: 8];
                rd_hit = 1'b1;
            end
            if (hit_c9[i]) begin
                rd_byte = rd_c9[i*8 +: 8];
                rd_hit = 1'b1;
            end
            if (hit_c10[i]) begin
                rd_byte = rd_c10[i*8 +: 8];
                rd_hit = 1'b1;
            end
            if (hit_res[i]) begin
                rd_byte = rd_res[i*8 +: 8];
                rd_hit = 1'b1;
            end
        end
    end

    always_ff @(posedge clock_i or negedge rstn_i) begin
        if (!rstn_i) begin
            prdata_q <= 32'h0000_0000;
            pslverr_q <= 1'b0;
        end else if (setup_phase) begin
            prdata_q <= pwrite_i ? 32'h0000_0000 : {24'h00_0000, rd_byte};
            pslverr_q <= !rd_hit;
        end
    end

    assign prdata_o = prdata_q;
    assign pready_o = 1'b1;
    assign pslverr_o = psel_i && penable_i && pslverr_q;
    assign an_restart_o = restart_q;
    assign transmitter_off_o = tx_off_q;
    assign line_transmit_pair_o = tx_data_q;
    assign line_transmit_valid_o = tx_valid_q;
    assign port_led_out_0_o = led0_q;
    assign port_led_out_1_o = led1_q;
    assign port_led_out_2_o = led2_q;
endmodule : pcr_port_regs

/* File: pcr_pkg.sv */
package pcr_pkg;
    // Register indices; the byte address is four times the index
    localparam logic [7:0] PORT1_LOOPBACK_CONTROL_IDX = 8'h1A;
    localparam logic [7:0] PORT1_NEGOTIATION_CONTROL_IDX = 8'h1C;
    localparam logic [7:0] PORT1_LED_TX_CONTROL_IDX = 8'h1D;
    localparam logic [7:0] PORT2_NEGOTIATION_CONTROL_IDX = 8'h2C;
    localparam logic [7:0] PORT2_LED_TX_CONTROL_IDX = 8'h2D;
    localparam logic [7:0] PORT3_CABLE_FAULT_DISTANCE_IDX = 8'h3B;
    localparam logic [7:0] PORT3_NEGOTIATION_CONTROL_IDX = 8'h3C;
    localparam logic [7:0] PORT3_LED_TX_CONTROL_IDX = 8'h3D;
    localparam logic [7:0] PORT4_CABLE_FAULT_DISTANCE_IDX = 8'h4B;
    localparam logic [7:0] PORT4_NEGOTIATION_CONTROL_IDX = 8'h4C;
    localparam logic [7:0] PORT4_LED_TX_CONTROL_IDX = 8'h4D;
    localparam logic [7:0] PORT_STRIDE = 8'h10;

    // Loopback / cable diagnostic control register fields
    localparam int C8_SHORT10_BIT = 7;
    localparam int C8_OUTCOME_LSB = 5;
    localparam int C8_GO_BIT = 4;
    localparam int C8_LOOPBACK_BIT = 1;
    localparam int C8_COUNT8_BIT = 0;

    // Negotiation control fields
    localparam int C9_AN_DISABLE_BIT = 7;
    localparam int C9_SPEED_BIT = 6;
    localparam int C9_DUPLEX_BIT = 5;
    localparam logic [4:0] C9_RESERVED_VALUE = 5'h1f;
    localparam logic C9_AN_DISABLE_RESET = 1'b0;
    localparam logic C9_SPEED_RESET = 1'b1;
    localparam logic C9_DUPLEX_RESET = 1'b0;

    // LED / transmitter control fields
    localparam int C10_LED_OFF_BIT = 7;
    localparam int C10_TX_OFF_BIT = 6;
    localparam int C10_RESTART_BIT = 5;

    // Cable test outcome codes
    typedef enum logic [1:0] {
        PCR_CABLE_NORMAL = 2'h0,
        PCR_CABLE_OPEN = 2'h1,
        PCR_CABLE_SHORT = 2'h2,
        PCR_CABLE_FAILED = 2'h3
    } pcr_outcome_t;

    localparam logic [8:0] FAULT_COUNT_RESET = 9'h000;
    localparam int PORT_COUNT = 4;
    localparam logic [3:0] COPPER_PORTS = 4'b1100;
    localparam int NIBBLE_W = 4;
endpackage : pcr_pkg

/* File: pcr_cable_test.sv */
`timescale 1ns/1ps
module pcr_cable_test
    import pcr_pkg::*;
(
    input wire logic clock_i,
    input wire logic rstn_i,
    input wire logic go_write_i,
    input wire logic done_i,
    input wire logic [1:0] outcome_i,
    input wire logic [8:0] count_i,
    input wire logic short10_i,
    output logic busy_o,
    output logic start_o,
    output logic [1:0] outcome_o,
    output logic [8:0] count_o,
    output logic short10_o
);
    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_START = 3'b010,
        ST_RUN = 3'b100
    } pcr_ct_state_t;

    pcr_ct_state_t state_q;
    pcr_ct_state_t state_d;

    always_comb begin
        state_d = state_q;
        case (state_q)
            ST_IDLE: begin
                if (go_write_i) begin
                    state_d = ST_START;
                end
            end
            ST_START: begin
                state_d = ST_RUN;
            end
            ST_RUN: begin
                if (done_i && !go_write_i) begin
                    state_d = ST_IDLE;
                end
            end
            default: begin
                state_d = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge clock_i or negedge rstn_i) begin
        if (!rstn_i) begin
            state_q <= ST_IDLE;
        end else begin
            state_q <= state_d;
        end
    end

    // A go written in the cycle a test finishes keeps it in ST_RUN, busy, with no new start pulse
    always_ff @(posedge clock_i or negedge rstn_i) begin
        if (!rstn_i) begin
            outcome_o <= PCR_CABLE_NORMAL;
            count_o <= FAULT_COUNT_RESET;
            short10_o <= 1'b0;
        end else if (state_q == ST_RUN && done_i) begin
            outcome_o <= outcome_i;
            count_o <= count_i;
            short10_o <= short10_i;
        end
    end

    assign busy_o = (state_q != ST_IDLE);
    assign start_o = (state_q == ST_START);
endmodule : pcr_cable_test

/* File: pcr_port_regs_properties.sv */
`timescale 1ns/1ps
module pcr_port_regs_chk
    import pcr_pkg::*;
#(
    parameter int ADDR_W = 12,
    parameter int NPORT = 4
) (
    input wire logic clock_i,
    input wire logic rstn_i,
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [ADDR_W-1:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    input wire logic [3:0] pstrb_i,
    input wire logic pslverr_o,
    input wire logic [NPORT-1:0] an_speed_100_i,
    input wire logic [NPORT-1:0] an_full_duplex_i,
    input wire logic [NPORT-1:0] an_failed_i,
    input wire logic [NPORT-1:0] an_enable_o,
    input wire logic [NPORT-1:0] an_restart_o,
    input wire logic [NPORT-1:0] link_speed_100_o,
    input wire logic [NPORT-1:0] link_full_duplex_o,
    input wire logic [NPORT*3-1:0] led_normal_i,
    input wire logic [NPORT-1:0] port_led_out_0_o,
    input wire logic [NPORT-1:0] transmitter_off_o,
    input wire logic [NPORT-1:0] line_transmit_valid_o,
    input wire logic [NPORT-1:0] cable_test_start_o
);
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (!rstn_i);

    // Negotiated ports pass the engine's speed straight through
    property p_speed; (link_speed_100_o & an_enable_o) == (an_speed_100_i & an_enable_o);
    endproperty
    a_speed: assert property (p_speed)
        else $error("negotiated speed not passed through");
    property p_duplex;
        (link_full_duplex_o & an_enable_o & ~an_failed_i)
            == (an_full_duplex_i & an_enable_o & ~an_failed_i);
    endproperty
    a_duplex: assert property (p_duplex)
        else $error("negotiated duplex not passed through");
    property p_led; port_led_out_0_o[0] != $past(led_normal_i[0]) |-> port_led_out_0_o[0];
    endproperty
    a_led: assert property (p_led)
        else $error("led differs from normal but is not blanked");
    property p_txoff; transmitter_off_o[0] |=> !line_transmit_valid_o[0]; endproperty
    a_txoff: assert property (p_txoff)
        else $error("transmit valid while transmitter off");
    property p_restart;
        psel_i && penable_i && pwrite_i && pstrb_i[0] && pwdata_i[5]
            && paddr_i == {2'b00, PORT1_LED_TX_CONTROL_IDX, 2'b00} |-> ##[1:2] an_restart_o[0];
    endproperty
    a_restart: assert property (p_restart)
        else $error("restart write gave no pulse");
    property p_restart_once; an_restart_o[0] |=> !an_restart_o[0]; endproperty
    a_restart_once: assert property (p_restart_once)
        else $error("restart pulse longer than one cycle");
    property p_copper; cable_test_start_o[1:0] == 2'b00; endproperty
    a_copper: assert property (p_copper)
        else $error("cable test started on a fibre port");
    property p_err; pslverr_o |-> psel_i && penable_i; endproperty
    a_err: assert property (p_err)
        else $error("error flag outside access phase");
endmodule : pcr_port_regs_chk

bind pcr_port_regs pcr_port_regs_chk #(.ADDR_W(ADDR_W), .NPORT(NPORT)) u_chk (
    .clock_i(clock_i), .rstn_i(rstn_i), .psel_i(psel_i), .penable_i(penable_i),
    .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .pstrb_i(pstrb_i),
    .pslverr_o(pslverr_o), .an_speed_100_i(an_speed_100_i),
    .an_full_duplex_i(an_full_duplex_i), .an_failed_i(an_failed_i),
    .an_enable_o(an_enable_o), .an_restart_o(an_restart_o),
    .link_speed_100_o(link_speed_100_o), .link_full_duplex_o(link_full_duplex_o),
    .led_normal_i(led_normal_i), .port_led_out_0_o(port_led_out_0_o),
    .transmitter_off_o(transmitter_off_o), .line_transmit_valid_o(line_transmit_valid_o),
    .cable_test_start_o(cable_test_start_o)
);

/* File: port_phy_control_regs_tb.sv */
`timescale 1ns/1ps
module port_phy_control_regs_tb;
    import pcr_pkg::*;
    typedef struct {logic [7:0] idx; logic [7:0] wd; logic [7:0] rd; logic err;} pcr_row_t;
    logic clock_i, rstn_i, psel_i, penable_i, pwrite_i, pready_o, pslverr_o;
    logic [11:0] paddr_i, ledn;
    logic [31:0] pwdata_i, prdata_o;
    logic [3:0] pstrb_i, rxv, mtxv, txv, txoff, spd_i, fdx_i, fail_i, anen, rst_an;
    logic [3:0] spd_o, fdx_o, led0, led1, led2, start, done, sh;
    logic [15:0] rxd, mtxd, txd;
    logic [7:0] outc;
    logic [35:0] cnt;
    int bad_count = 0;
    int cmp_count = 0;
    // Fibre-port result slot and the fifth-port slot must both be refused
    pcr_row_t rows[10] = '{'{8'h1C, 8'hE0, 8'hFF, 1'b0}, '{8'h2C, 8'h00, 8'h1F, 1'b0},
        '{8'h3C, 8'hA0, 8'hBF, 1'b0}, '{8'h4C, 8'h40, 8'h5F, 1'b0},
        '{8'h1D, 8'hC0, 8'hC0, 1'b0}, '{8'h2D, 8'h80, 8'h80, 1'b0},
        '{8'h3B, 8'hFF, 8'h00, 1'b0}, '{8'h3A, 8'h02, 8'h02, 1'b0},
        '{8'h1B, 8'h55, 8'h00, 1'b1}, '{8'h5C, 8'h55, 8'h00, 1'b1}};

    pcr_port_regs #(.ADDR_W(12), .NPORT(4)) uut (
        .clock_i(clock_i), .rstn_i(rstn_i), .psel_i(psel_i), .penable_i(penable_i),
        .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .pstrb_i(pstrb_i),
        .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o),
        .line_receive_pair_i(rxd), .line_receive_valid_i(rxv), .mac_tx_data_i(mtxd),
        .mac_tx_valid_i(mtxv), .line_transmit_pair_o(txd), .line_transmit_valid_o(txv),
        .transmitter_off_o(txoff), .an_speed_100_i(spd_i), .an_full_duplex_i(fdx_i),
        .an_failed_i(fail_i), .an_enable_o(anen), .an_restart_o(rst_an),
        .link_speed_100_o(spd_o), .link_full_duplex_o(fdx_o), .led_normal_i(ledn),
        .port_led_out_0_o(led0), .port_led_out_1_o(led1), .port_led_out_2_o(led2),
        .cable_test_start_o(start), .cable_test_done_i(done), .cable_test_outcome_i(outc),
        .fault_distance_count_i(cnt), .cable_short10_i(sh)
    );

    initial begin
        clock_i = 1'b0;
        forever #5 clock_i = ~clock_i;
    end

    task automatic wrap_up();
        $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
        if (bad_count == 0 && cmp_count > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : wrap_up

    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            bad_count++;
            $display("[ERR] %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk

    // Idle edge first, so a release never meets the next setup in one time step
    task automatic apb(input logic wr, input logic [7:0] idx, input logic [7:0] wd,
                       output logic [7:0] rd, output logic er);
        @(posedge clock_i);
        psel_i <= 1'b1;
        pwrite_i <= wr;
        paddr_i <= {2'b00, idx, 2'b00};
        pwdata_i <= {24'h00_0000, wd};
        @(posedge clock_i);
        penable_i <= 1'b1;
        // Only the watchdog ends a wait that never sees pready
        do begin
            @(posedge clock_i);
        end while (pready_o !== 1'b1);
        rd = prdata_o[7:0];
        er = pslverr_o;
        psel_i <= 1'b0;
        penable_i <= 1'b0;
    endtask : apb

    initial begin
        #50000;
        bad_count++;
        wrap_up();
    end

    initial begin
        logic [7:0] rd;
        logic [7:0] rd8;
        logic e;
        int k;
        rstn_i = 1'b0;
        psel_i = 1'b0;
        penable_i = 1'b0;
        pwrite_i = 1'b0;
        paddr_i = '0;
        pwdata_i = '0;
        pstrb_i = 4'hF;
        rxd = 16'h3A21;
        mtxd = 16'h9657;
        rxv = 4'hF;
        mtxv = 4'hF;
        spd_i = 4'h0;
        fdx_i = 4'hF;
        fail_i = 4'h8;
        ledn = '0;
        done = '0;
        outc = '0;
        cnt = '0;
        sh = '0;
        repeat (2) @(posedge clock_i);
        chk("led_rst", {led2, led1, led0}, 12'hFFF);
        chk("anen_rst", anen, 4'hF);
        rstn_i <= 1'b1;
        for (int n = 0; n < 4; n++) begin
            apb(1'b0, 8'h1C + 8'(16 * n), 8'h00, rd, e);
            chk("ctrl9_rst", rd, 8'h5F);
            apb(1'b0, 8'h1D + 8'(16 * n), 8'h00, rd, e);
            chk("ctrl10_rst", rd, 8'h00);
        end
        apb(1'b0, 8'h4B, 8'h00, rd, e);
        chk("result_rst", rd, 8'h00);
        $display("test reset done");
        foreach (rows[i]) begin
            apb(1'b1, rows[i].idx, rows[i].wd, rd, e);
            chk("wr_err", e, rows[i].err);
            apb(1'b0, rows[i].idx, 8'h00, rd, e);
            chk("rd_data", rd, rows[i].rd);
            chk("rd_err", e, rows[i].err);
        end
        chk("an_enable", anen, 4'b1010);
        chk("speed", spd_o, 4'b0001);
        chk("duplex", fdx_o, 4'b0111);
        chk("leds", {led2, led1, led0}, 12'h333);
        // Unblanked ports must follow their normal levels, blanked ones stay high
        ledn <= 12'hE80;
        repeat (2) @(posedge clock_i);
        chk("leds_follow", {led2, led1, led0}, 12'hBFB);
        chk("tx_off", txoff, 4'b0001);
        chk("tx_data", txd, 16'h9A50);
        chk("tx_valid", txv, 4'b1110);
        $display("test table done");
        apb(1'b1, 8'h1D, 8'hE0, rd, e);
        k = 0;
        repeat (4) begin
            @(posedge clock_i);
            if (rst_an[0] === 1'b1) k++;
        end
        chk("restart_pulses", k, 1);
        apb(1'b0, 8'h1D, 8'h00, rd, e);
        chk("restart_clear", rd, 8'hC0);
        $display("test restart done");
        for (int n = 0; n < 4; n++) begin
            apb(1'b1, 8'h3A, 8'h12, rd, e);
            k = 0;
            repeat (4) begin
                @(posedge clock_i);
                if (start[2] === 1'b1) k++;
            end
            chk("start_pulses", k, 1);
            apb(1'b0, 8'h3A, 8'h00, rd, e);
            chk("busy", rd[4], 1'b1);
            done[2] <= 1'b1;
            outc[5:4] <= 2'(n);
            cnt[26:18] <= 9'h1C4 + 9'(n);
            sh[2] <= n[0];
            @(posedge clock_i);
            done[2] <= 1'b0;
            apb(1'b0, 8'h3A, 8'h00, rd8, e);
            chk("ctrl8", rd8, {n[0], n[1:0], 5'b0_0011});
            apb(1'b0, 8'h3B, 8'h00, rd, e);
            chk("count_low", rd, 8'hC4 + 8'(n));
            // Software joins both halves before scaling by the per-count distance
            chk("count9", {rd8[0], rd}, 9'h1C4 + 9'(n));
        end
        $display("test cable done");
        rstn_i <= 1'b0;
        @(posedge clock_i);
        chk("led_mid_rst", {led2, led1, led0}, 12'hFFF);
        chk("txoff_mid_rst", txoff, 4'h0);
        rstn_i <= 1'b1;
        apb(1'b0, 8'h1C, 8'h00, rd, e);
        chk("ctrl9_mid_rst", rd, 8'h5F);
        apb(1'b0, 8'h1D, 8'h00, rd, e);
        chk("ctrl10_mid_rst", rd, 8'h00);
        $display("test mid reset done");
        wrap_up();
    end
endmodule : port_phy_control_regs_tb
